/* logic/ssr_defs.svh */
// constants shared by the sample stamp rebuilder files
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

// record field widths
`define SSR_EV_W             32
`define SSR_TM_W             32
`define SSR_ST_W             16
`define SSR_STAMP_W          48
`define SSR_Q_W              32
`define SSR_DIV_W            64

// status field layout
`define SSR_INTERP_MSB       5
`define SSR_BLK_START_BIT    6
`define SSR_SUPPRESS_BIT     7

// stamp arithmetic, times in picoseconds
`define SSR_TICK_PS          2000
`define SSR_INTERP_PS        100
`define SSR_PRESCALE_SHIFT   2
`define SSR_DEG_FULL         64'h0000000000000168
`define SSR_FREQ_SCALE       64'h00000002540be400

// default correction values, stamp units of 0.1 ns, timer ticks or events
`define SSR_EV_OVF_DEF       48'h000100000000
`define SSR_TM_OVF_DEF       48'h000100000000
`define SSR_PATH_OFS_DEF     48'h000000000000
`define SSR_REF_PERIOD_DEF   48'h000000002710
`define SSR_FIFO_DEPTH       4

`endif

/* logic/ssr_divider.sv */
// serial restoring divider, one quotient bit per clock
`timescale 1ns/10ps

module ssr_divider #(
   parameter int W = 64
) (
   // clock and reset
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   // request
   input  wire logic         i_start,
   input  wire logic [W-1:0] i_num,
   input  wire logic [W-1:0] i_den,
   // answer
   output logic              o_done,
   output logic [W-1:0]      o_quot
);
   localparam int CW = $clog2(W + 1);

   logic [W-1:0]  rem;
   logic [CW-1:0] cnt;
   logic          busy;

   // a zero divisor gives an all-ones quotient
   wire [W:0]   trial    = {rem, o_quot[W-1]};
   wire         fits     = trial >= {1'b0, i_den};
   wire [W:0]   trial_sb = trial - {1'b0, i_den};
   wire [W-1:0] next_rem = fits ? trial_sb[W-1:0] : trial[W-1:0];

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rem    <= '0;
         cnt    <= '0;
         busy   <= 1'b0;
         o_done <= 1'b0;
         o_quot <= '0;
      end else if (i_start) begin
         rem    <= '0;
         cnt    <= CW'(W);
         busy   <= 1'b1;
         o_done <= 1'b0;
         o_quot <= i_num;
      end else if (busy) begin
         rem    <= next_rem;
         o_quot <= {o_quot[W-2:0], fits};
         cnt    <= cnt - CW'(1);
         busy   <= (cnt != CW'(1));
         o_done <= (cnt == CW'(1));
      end else begin
         o_done <= 1'b0;
      end
   end

endmodule : ssr_divider

/* logic/ssr_fifo.sv */
// result fifo with a registered output stage
`timescale 1ns/10ps

module ssr_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   // fill side
   input  wire logic         i_valid,
   input  wire logic [W-1:0] i_data,
   output logic              o_ready,
   // drain side
   output logic              o_valid,
   output logic [W-1:0]      o_data,
   input  wire logic         i_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] count;

   wire push     = i_valid && o_ready;
   wire load_out = (!o_valid || i_ready) && (count != '0);

   assign o_ready = (count != CW'(DEPTH));

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : ptr_inc

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_data;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         count   <= '0;
         o_valid <= 1'b0;
         o_data  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= ptr_inc(wr_ptr);
         end
         if (load_out) begin
            rd_ptr <= ptr_inc(rd_ptr);
            o_data <= mem[rd_ptr];
         end
         count   <= count + CW'(push) - CW'(load_out);
         o_valid <= load_out || (o_valid && !i_ready);
      end
   end

endmodule : ssr_fifo

/* logic/ssr_pkg.sv */
// types shared by the sample stamp rebuilder files
`include "ssr_defs.svh"

package ssr_pkg;

   typedef logic [`SSR_STAMP_W-1:0] ssr_stamp_t;
   typedef logic [`SSR_Q_W-1:0]     ssr_quot_t;

   // one incoming record: event or unused, unused, time, interpolator/status
   typedef struct packed {
      logic [`SSR_EV_W-1:0] ev;
      logic [`SSR_EV_W-1:0] unused;
      logic [`SSR_TM_W-1:0] tm;
      logic [`SSR_ST_W-1:0] st;
   } ssr_rec_s;

   // one result word
   typedef struct packed {
      logic       arming;
      logic       suppressed;
      ssr_stamp_t interval;
      ssr_stamp_t missed;
      ssr_quot_t  freq;
      ssr_quot_t  period;
      ssr_stamp_t tdev;
      ssr_quot_t  phase;
   } ssr_res_s;

   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,
      S_EVAL  = 3'h1,
      S_DIVF  = 3'h2,
      S_DIVP  = 3'h3,
      S_DIVPH = 3'h4,
      S_PUSH  = 3'h5
   } ssr_state_e;

endpackage : ssr_pkg

/* logic/ssr_rebuilder.sv */
// sample stamp rebuilder: raw records in, corrected results out
`timescale 1ns/10ps
`include "ssr_defs.svh"

module ssr_rebuilder #(
   // corrections, offset and period are parameters
   parameter logic [`SSR_STAMP_W-1:0] EV_OVF      = `SSR_EV_OVF_DEF,
   parameter logic [`SSR_STAMP_W-1:0] TM_OVF      = `SSR_TM_OVF_DEF,
   parameter logic [`SSR_STAMP_W-1:0] PATH_OFFSET = `SSR_PATH_OFS_DEF,
   parameter logic [`SSR_STAMP_W-1:0] REF_PERIOD  = `SSR_REF_PERIOD_DEF,
   parameter int                      FIFO_DEPTH  = `SSR_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   // raw record stream
   input  wire logic              i_rec_valid,
   input  wire ssr_pkg::ssr_rec_s i_rec,
   output logic                   o_rec_ready,
   // measurement on the prescaled channel
   input  wire logic              i_prescaled,
   // result stream
   output logic                   o_res_valid,
   output ssr_pkg::ssr_res_s      o_res,
   input  wire logic              i_res_ready
);
   localparam int SW = `SSR_STAMP_W;
   localparam int DW = `SSR_DIV_W;
   localparam int QW = `SSR_Q_W;
   localparam int RW = $bits(ssr_pkg::ssr_res_s);
   localparam logic [SW-1:0] TICK_RATIO = SW'(`SSR_TICK_PS / `SSR_INTERP_PS);

   // ===========================================================
   // helper functions
   // ===========================================================
   function automatic logic [SW-1:0] mag(input logic [SW-1:0] v);
      mag = v[SW-1] ? (~v + SW'(1)) : v;
   endfunction : mag

   // quotients beyond the result width saturate
   function automatic logic [QW-1:0] sat_q(input logic [DW-1:0] q);
      sat_q = (q[DW-1:QW] != '0) ? '1 : q[QW-1:0];
   endfunction : sat_q

   // ===========================================================
   // state
   // ===========================================================
   ssr_pkg::ssr_state_e state;
   ssr_pkg::ssr_state_e next_state;

   logic [`SSR_EV_W-1:0] prev_ev_raw;
   logic [`SSR_TM_W-1:0] prev_tm_raw;
   logic                 have_ev;
   logic                 have_tm;
   logic [SW-1:0]        ev_acc;
   logic [SW-1:0]        tm_acc;

   logic [SW-1:0]        cur_es;
   logic [SW-1:0]        cur_ts;
   logic                 cur_first;
   logic                 cur_supp;
   logic [SW-1:0]        prev_es;
   logic [SW-1:0]        prev_ts;
   logic                 have_prev;
   logic                 arm_pend;
   logic [SW-1:0]        ref_es;
   logic [SW-1:0]        ref_ts;

   ssr_pkg::ssr_res_s    res;
   logic                 div_go;
   logic [DW-1:0]        div_num;
   logic [DW-1:0]        div_den;
   logic                 div_done;
   logic [DW-1:0]        div_quot;
   logic                 fifo_ready;

   // ===========================================================
   // record decode and stamp correction
   // ===========================================================
   // record handshake
   wire accept = i_rec_valid && o_rec_ready;

   wire blk_first = i_rec.st[`SSR_BLK_START_BIT];
   // suppression flag, other status bits dropped
   wire suppress  = i_rec.st[`SSR_SUPPRESS_BIT];
   // interpolator sits in the low status bits
   wire [SW-1:0] interp = SW'(i_rec.st[`SSR_INTERP_MSB:0]);

   // event rollover, block-first event slot carries nothing
   wire ev_roll = !blk_first && have_ev && (i_rec.ev < prev_ev_raw);
   wire [SW-1:0] ev_acc_new = ev_roll ? ev_acc + EV_OVF : ev_acc;
   wire [SW-1:0] ev_corr    = SW'(i_rec.ev) + ev_acc_new;
   wire [SW-1:0] ev_stamp   = i_prescaled ? (ev_corr << `SSR_PRESCALE_SHIFT) : ev_corr;

   wire tm_roll = have_tm && (i_rec.tm < prev_tm_raw);
   wire [SW-1:0] tm_acc_new = tm_roll ? tm_acc + TM_OVF : tm_acc;
   wire [SW-1:0] tm_corr    = SW'(i_rec.tm) + tm_acc_new;
   wire [SW-1:0] ts_raw     = (tm_corr * TICK_RATIO) - interp;
   // offset only on the arming stamp
   wire [SW-1:0] ts_stamp   = blk_first ? ts_raw - PATH_OFFSET : ts_raw;

   // ===========================================================
   // pair differences
   // ===========================================================
   // elapsed time of the pair
   wire [SW-1:0] d_time   = cur_ts - prev_ts;
   wire [SW-1:0] d_event  = cur_es - prev_es;
   wire [SW-1:0] missed   = d_event - SW'(1);
   wire [SW-1:0] ref_de   = cur_es - ref_es;
   wire [SW-1:0] ref_dt   = cur_ts - ref_ts;
   wire [SW-1:0] ev_time  = ref_de * REF_PERIOD;
   wire [SW-1:0] tdev     = ev_time - ref_dt;

   // operand sets for the shared divider
   wire [DW-1:0] freq_num  = DW'(d_event) * `SSR_FREQ_SCALE;
   wire [DW-1:0] per_num   = DW'(res.interval);
   // elapsed events wrap to zero at 48 bits, so no-event pairs saturate
   wire [SW-1:0] per_ev    = res.missed + SW'(1);
   wire [DW-1:0] per_den   = DW'(per_ev);
   // phase from magnitude, sign restored afterwards
   wire [DW-1:0] ph_num    = DW'(mag(res.tdev)) * `SSR_DEG_FULL;
   wire [QW-1:0] ph_mag    = sat_q(div_quot);
   wire [QW-1:0] ph_signed = res.tdev[SW-1] ? (~ph_mag + QW'(1)) : ph_mag;

   wire          push_res  = (state == ssr_pkg::S_PUSH) && fifo_ready;

   // ===========================================================
   // sequencing
   // ===========================================================
   always_comb begin
      next_state = state;
      unique case (state)
         ssr_pkg::S_IDLE: begin
            if (accept) begin
               next_state = ssr_pkg::S_EVAL;
            end
         end
         ssr_pkg::S_EVAL: begin
            if (cur_first || !have_prev) begin
               next_state = ssr_pkg::S_IDLE;
            end else if (arm_pend) begin
               next_state = ssr_pkg::S_PUSH;
            end else begin
               next_state = ssr_pkg::S_DIVF;
            end
         end
         ssr_pkg::S_DIVF: begin
            if (div_done) begin
               next_state = ssr_pkg::S_DIVP;
            end
         end
         ssr_pkg::S_DIVP: begin
            if (div_done) begin
               next_state = ssr_pkg::S_DIVPH;
            end
         end
         ssr_pkg::S_DIVPH: begin
            if (div_done) begin
               next_state = ssr_pkg::S_PUSH;
            end
         end
         ssr_pkg::S_PUSH: begin
            if (fifo_ready) begin
               next_state = ssr_pkg::S_IDLE;
            end
         end
         default: begin
            next_state = ssr_pkg::S_IDLE;
         end
      endcase
   end

   // ready is registered: one record in flight at a time
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state       <= ssr_pkg::S_IDLE;
         o_rec_ready <= 1'b0;
      end else begin
         state       <= next_state;
         o_rec_ready <= (next_state == ssr_pkg::S_IDLE);
      end
   end

   // ===========================================================
   // rollover tracking and stamp capture
   // ===========================================================
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         prev_ev_raw <= '0;
         prev_tm_raw <= '0;
         have_ev     <= 1'b0;
         have_tm     <= 1'b0;
         ev_acc      <= '0;
         tm_acc      <= '0;
         cur_es      <= '0;
         cur_ts      <= '0;
         cur_first   <= 1'b0;
         cur_supp    <= 1'b0;
      end else if (accept) begin
         // the arming sample leaves the event history alone
         if (!blk_first) begin
            prev_ev_raw <= i_rec.ev;
            have_ev     <= 1'b1;
            ev_acc      <= ev_acc_new;
         end
         // every sample feeds the time history
         prev_tm_raw <= i_rec.tm;
         have_tm     <= 1'b1;
         tm_acc      <= tm_acc_new;
         cur_es      <= ev_stamp;
         cur_ts      <= ts_stamp;
         cur_first   <= blk_first;
         cur_supp    <= suppress;
      end
   end

   // ===========================================================
   // pair history and reference sample
   // ===========================================================
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         prev_es   <= '0;
         prev_ts   <= '0;
         have_prev <= 1'b0;
         arm_pend  <= 1'b0;
         ref_es    <= '0;
         ref_ts    <= '0;
      end else if (state == ssr_pkg::S_EVAL) begin
         prev_ts   <= cur_ts;
         have_prev <= 1'b1;
         arm_pend  <= cur_first;
         // the arming sample has no event stamp to pair with
         if (!cur_first) begin
            prev_es <= cur_es;
         end
         // first sample after arming becomes the reference
         if (!cur_first && arm_pend) begin
            ref_es <= cur_es;
            ref_ts <= cur_ts;
         end
      end
   end

   // ===========================================================
   // result assembly and divider control
   // ===========================================================
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         res     <= '0;
         div_go  <= 1'b0;
         div_num <= '0;
         div_den <= '0;
      end else begin
         div_go <= 1'b0;
         unique case (state)
            ssr_pkg::S_EVAL: begin
               res            <= '0;
               res.suppressed <= cur_supp;
               // interval field carries the pair's elapsed time
               res.interval   <= d_time;
               // arming pair reports arming data only
               res.arming     <= arm_pend;
               if (!arm_pend) begin
                  res.missed <= missed;
                  res.tdev   <= tdev;
                  div_num    <= freq_num;
                  div_den    <= DW'(d_time);
                  div_go     <= !cur_first && have_prev;
               end
            end
            ssr_pkg::S_DIVF: begin
               if (div_done) begin
                  res.freq <= sat_q(div_quot);
                  div_num  <= per_num;
                  div_den  <= per_den;
                  div_go   <= 1'b1;
               end
            end
            ssr_pkg::S_DIVP: begin
               if (div_done) begin
                  res.period <= sat_q(div_quot);
                  div_num    <= ph_num;
                  div_den    <= DW'(REF_PERIOD);
                  div_go     <= 1'b1;
               end
            end
            ssr_pkg::S_DIVPH: begin
               if (div_done) begin
                  // lag shows as a negative phase
                  res.phase <= ph_signed;
               end
            end
            default: begin
               res <= res;
            end
         endcase
      end
   end

   // ===========================================================
   // shared divider and output fifo
   // ===========================================================
   // one divider shared by all three quotients trades latency for area
   ssr_divider #(
      .W (DW)
   ) u_div (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_start    (div_go),
      .i_num      (div_num),
      .i_den      (div_den),
      .o_done     (div_done),
      .o_quot     (div_quot)
   );

   // result handshake; a stalled consumer backs up into record ready
   ssr_fifo #(
      .W     (RW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_valid    (push_res),
      .i_data     (res),
      .o_ready    (fifo_ready),
      .o_valid    (o_res_valid),
      .o_data     (o_res),
      .i_ready    (i_res_ready)
   );

endmodule : ssr_rebuilder

/* tb/ssr_rebuilder_sva.sv */
// port checker for the sample stamp rebuilder
`timescale 1ns/10ps
module ssr_rebuilder_sva (
   // clock and reset
   input wire logic              i_core_clk,
   input wire logic              i_rst_n,
   // record and result streams
   input wire logic              i_rec_valid,
   input wire ssr_pkg::ssr_rec_s i_rec,
   input wire logic              o_rec_ready,
   input wire logic              i_prescaled,
   input wire logic              o_res_valid,
   input wire ssr_pkg::ssr_res_s o_res,
   input wire logic              i_res_ready
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   wire        take = i_rec_valid && o_rec_ready;
   wire        norm = o_res_valid && !o_res.arming;
   wire [63:0] ev_n = 64'(o_res.missed) + 64'h1;
   wire [63:0] prod = 64'(o_res.period) * ev_n;
   // ==========================================
   // handshakes
   property p_rst;
      disable iff (1'b0) !i_rst_n |=> !o_rec_ready && !o_res_valid;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   property p_drop;
      take |=> !o_rec_ready;
   endproperty
   a_drop: assert property (p_drop) else $error("ready stayed high after a take");
   property p_rdy;
      o_rec_ready && !i_rec_valid |=> o_rec_ready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready dropped with no take");
   property p_hold;
      o_res_valid && !i_res_ready |=> o_res_valid && $stable(o_res);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed while stalled");
   property p_blk;
      take && i_rec.st[6] |-> ##2 o_rec_ready;
   endproperty
   a_blk: assert property (p_blk) else $error("block-first record not passed quickly");
   // ==========================================
   // result fields
   property p_arm;
      o_res_valid && o_res.arming |-> o_res.missed == 48'h0 && o_res.freq == 32'h0
         && o_res.period == 32'h0 && o_res.tdev == 48'h0 && o_res.phase == 32'h0;
   endproperty
   a_arm: assert property (p_arm) else $error("arming result carries data");
   property p_div0;
      norm && o_res.missed == 48'hffffffffffff |-> o_res.period == 32'hffffffff;
   endproperty
   a_div0: assert property (p_div0) else $error("period not saturated");
   property p_per;
      norm && o_res.period != 32'hffffffff && o_res.missed != 48'hffffffffffff
         && !o_res.interval[47] |-> prod <= 64'(o_res.interval)
         && prod + ev_n > 64'(o_res.interval);
   endproperty
   a_per: assert property (p_per) else $error("period not interval over events");
   property p_sign;
      norm |-> o_res.tdev[47] == o_res.phase[31] || o_res.phase == 32'h0;
   endproperty
   a_sign: assert property (p_sign) else $error("phase sign differs from deviation");
   c_arm: cover property (o_res_valid && o_res.arming);
   c_full: cover property (!o_rec_ready && o_res_valid && !i_res_ready);
   c_lag: cover property (norm && o_res.tdev[47]);
endmodule : ssr_rebuilder_sva

bind ssr_rebuilder ssr_rebuilder_sva chk_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
   .i_rec_valid(i_rec_valid), .i_rec(i_rec), .o_rec_ready(o_rec_ready),
   .i_prescaled(i_prescaled), .o_res_valid(o_res_valid), .o_res(o_res),
   .i_res_ready(i_res_ready));

/* tb/ssr_src_model.sv */
// behavioural source of raw sample records
`timescale 1ns/10ps
module ssr_src_model (
   // clock and reset
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   // record stream
   input  wire logic         i_ready,
   output logic              o_valid,
   output ssr_pkg::ssr_rec_s o_rec,
   output logic              o_prescaled
);
   ssr_pkg::ssr_rec_s q_rec[$];
   logic              q_pre[$];
   int                q_gap[$];
   int                wait_n = 0;
   initial begin
      o_valid = 1'b0;
      o_rec = '0;
      o_prescaled = 1'b0;
   end
   function automatic void push(ssr_pkg::ssr_rec_s r, logic pre, int gap);
      q_rec.push_back(r);
      q_pre.push_back(pre);
      q_gap.push_back(gap);
   endfunction : push
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
      end else if (o_valid && i_ready) begin
         o_valid <= 1'b0;
         o_rec <= ~o_rec;
         o_prescaled <= ~o_prescaled;
      end else if (!o_valid && q_rec.size() > 0) begin
         if (wait_n < q_gap[0]) begin
            wait_n <= wait_n + 1;
         end else begin
            wait_n <= 0;
            o_valid <= 1'b1;
            o_rec <= q_rec.pop_front();
            o_prescaled <= q_pre.pop_front();
            void'(q_gap.pop_front());
         end
      end
   end
endmodule : ssr_src_model

/* tb/tb_ssr_rebuilder.sv */
// self-checking bench for the sample stamp rebuilder
`timescale 1ns/10ps
`include "ssr_defs.svh"
module tb_ssr_rebuilder;
   localparam logic [47:0] PATH_OFS = 48'h000000000123;
   localparam logic [47:0] OVF      = 48'h000100000000;
   localparam logic [47:0] REF_P    = 48'h000000002710;
   logic              i_core_clk;
   logic              i_rst_n = 1'b0;
   logic              rec_valid;
   ssr_pkg::ssr_rec_s rec;
   logic              rec_ready;
   logic              prescaled;
   logic              res_valid;
   ssr_pkg::ssr_res_s res;
   logic              res_ready = 1'b0;
   logic              stall = 1'b0;
   logic [15:0]       seed = 16'h0018;
   logic [15:0]       rbits = 16'h0018;
   int                bad_count = 0;
   int                cmp_count = 0;
   int                cycles = 0;
   ssr_pkg::ssr_res_s exp_q[$];
   logic [31:0]       cur_ev, cur_tm, p_ev, p_tm;
   logic [47:0]       ev_ofs, tm_ofs, p_ts, p_es, r_ts, r_es;
   logic              have_p, p_first;

   initial begin
      i_core_clk = 1'b0;
      forever #20 i_core_clk = ~i_core_clk;
   end

   ssr_rebuilder #(.EV_OVF(OVF), .TM_OVF(OVF), .PATH_OFFSET(PATH_OFS), .REF_PERIOD(REF_P))
   dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_rec_valid(rec_valid), .i_rec(rec),
      .o_rec_ready(rec_ready), .i_prescaled(prescaled), .o_res_valid(res_valid),
      .o_res(res), .i_res_ready(res_ready));
   ssr_src_model src_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ready(rec_ready),
      .o_valid(rec_valid), .o_rec(rec), .o_prescaled(prescaled));

   // ==========================================
   // helpers
   function automatic logic [15:0] rnd(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : rnd

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   task automatic cmp_res(ssr_pkg::ssr_res_s got, ssr_pkg::ssr_res_s exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: result %h expected %h", $time, got, exp);
      end
   endtask : cmp_res

   task automatic cmp_bit(logic got, logic exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: flag %h expected %h", $time, got, exp);
      end
   endtask : cmp_bit

   function automatic void model_reset();
      {p_ev, p_tm, ev_ofs, tm_ofs, p_ts, p_es, r_ts, r_es, have_p, p_first} = '0;
   endfunction : model_reset

   function automatic void model_rec(ssr_pkg::ssr_rec_s r, logic pre);
      logic [47:0] ts, es, dt, de, td, mg;
      logic [63:0] q;
      ssr_pkg::ssr_res_s x;
      if (r.tm < p_tm) tm_ofs = tm_ofs + OVF;
      p_tm = r.tm;
      // stamp in 0.1 ns, offset on block-first only
      ts = (48'(r.tm) + tm_ofs) * 48'h14 - 48'(r.st[5:0]);
      if (r.st[6]) ts = ts - PATH_OFS;
      es = p_es;
      if (!r.st[6]) begin
         if (r.ev < p_ev) ev_ofs = ev_ofs + OVF;
         p_ev = r.ev;
         es = (48'(r.ev) + ev_ofs) << (pre ? 2 : 0);
      end
      x = '0;
      // besides the interpolator, only suppression and block-first bits count
      x.suppressed = r.st[7];
      dt = ts - p_ts;
      de = es - p_es;
      x.interval = dt;
      if (have_p && p_first && !r.st[6]) begin
         // arming result, reference sample for deviation
         x.arming = 1'b1;
         r_ts = ts;
         r_es = es;
         exp_q.push_back(x);
      end else if (have_p && !r.st[6]) begin
         x.missed = de - 48'h1;
         q = (dt == 48'h0) ? '1 : (64'(de) * `SSR_FREQ_SCALE) / 64'(dt);
         x.freq = (q > 64'hffffffff) ? '1 : q[31:0];
         x.period = (de == 48'h0) ? '1 : 32'(dt / de);
         td = (es - r_es) * REF_P - (ts - r_ts);
         x.tdev = td;
         mg = td[47] ? -td : td;
         q = 64'(mg) * `SSR_DEG_FULL / 64'(REF_P);
         x.phase = td[47] ? -q[31:0] : q[31:0];
         exp_q.push_back(x);
      end
      have_p = 1'b1;
      p_first = r.st[6];
      p_ts = ts;
      p_es = es;
   endfunction : model_rec

   // kind 0 slow source, 1 prompt, 3 one sample with no new events
   task automatic send_block(int n, logic pre, int kind);
      ssr_pkg::ssr_rec_s r;
      logic [15:0] v;
      logic [31:0] st;
      for (int i = 0; i < n; i++) begin
         seed = rnd(seed);
         v = seed;
         st = (kind == 3 && i == 3) ? 32'h0 : 32'(v[2:0]) + 32'h1;
         r.ev = (i == 0) ? {v, v} : cur_ev + st;
         r.unused = ~{v, v};
         r.tm = (i == 0) ? cur_tm + 32'h7 : cur_tm + (st + 32'(st == 0)) * 32'd500
            + 32'(v[13:8]) - 32'd32;
         r.st = {~v[7:0], v[3], i == 0, v[10:5]};
         if (i != 0) cur_ev = r.ev;
         cur_tm = r.tm;
         model_rec(r, pre);
         src_u.push(r, pre, (kind == 0) ? 32'(v[1:0]) * 5 : 0);
      end
   endtask : send_block

   task automatic drain();
      while (exp_q.size() != 0) @(posedge i_core_clk);
      repeat (3) @(posedge i_core_clk);
      #1;
      cmp_bit(res_valid, 1'b0);
   endtask : drain

   // ==========================================
   // consumer, monitor and timeout
   always @(posedge i_core_clk) begin
      rbits = rnd(rbits);
      res_ready <= !stall && rbits[1:0] != 2'b00;
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         report_and_stop();
      end
   end

   always @(posedge i_core_clk) begin
      if (i_rst_n && res_valid && res_ready)
         cmp_res(res, (exp_q.size() > 0) ? exp_q.pop_front() : 'x);
   end

   // ==========================================
   // main sequence
   initial begin
      int n;
      cur_ev = 32'h00000100;
      cur_tm = 32'h00001000;
      model_reset();
      repeat (6) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      send_block(6, 1'b0, 0);
      cur_ev = 32'hfffffffd;
      send_block(6, 1'b1, 1);
      drain();
      stall <= 1'b1;
      cur_tm = 32'hfffffffc;
      send_block(9, 1'b0, 1);
      n = 0;
      while (n < 300) begin
         @(posedge i_core_clk);
         n = rec_ready ? 0 : n + 1;
      end
      #1;
      cmp_bit(rec_ready, 1'b0);
      cmp_bit(res_valid, 1'b1);
      stall <= 1'b0;
      send_block(6, 1'b0, 3);
      drain();
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      model_reset();
      i_rst_n <= 1'b1;
      send_block(4, 1'b1, 1);
      drain();
      report_and_stop();
   end
endmodule : tb_ssr_rebuilder
